// file: core/rdas_consts.svh
// Register offsets, field positions, reset values and timing counts of the receive baseband block.
`ifndef RDAS_CONSTS_SVH
`define RDAS_CONSTS_SVH

// Register byte offsets on the APB port.
`define RDAS_OFF_CTRL      8'h00
`define RDAS_OFF_BW        8'h04
`define RDAS_OFF_CLKDIV    8'h08
`define RDAS_OFF_AFC       8'h0c
`define RDAS_OFF_SYNC      8'h10
`define RDAS_OFF_FEST      8'h14
`define RDAS_OFF_STAT      8'h18

// Field positions.
`define RDAS_CTRL_DSEL     1:0
`define RDAS_CTRL_SETUP    4:2
`define RDAS_CTRL_AFCEN    5
`define RDAS_CTRL_DOT      6
`define RDAS_CTRL_FLIP     7
`define RDAS_CTRL_SLEN     9:8
`define RDAS_CTRL_STOL     11:10
`define RDAS_BW_POST       9:0
`define RDAS_BW_DISC       25:16
`define RDAS_DIV_DEMOD     7:0
`define RDAS_DIV_CDR       15:8
`define RDAS_AFC_SCALE     15:0
`define RDAS_AFC_IFT       31:16
`define RDAS_SYNC_WORD     23:0

// Reset values.
`define RDAS_RST_POST      10'h009
`define RDAS_RST_DISC      10'h03f
`define RDAS_RST_SCALE     16'h0347
`define RDAS_RST_IFT       16'h051f
`define RDAS_RST_DDIV      8'h07
`define RDAS_RST_CDIV      8'h81
`define RDAS_RST_AFCLIM    16'h4000

// Timing and structure counts.
`define RDAS_OS_MID        5'd15
`define RDAS_OS_STEP       5'd1
`define RDAS_OS_LEAD       5'd2
`define RDAS_OS_HALF       5'd16
`define RDAS_HOLD_BITS     4'd9
`define RDAS_SYNC_MAXLEN   24
`define RDAS_SYNC_BASE     5'd12
`define RDAS_NSTAGE        3
`define RDAS_COEF_SHIFT    10
`define RDAS_AVG_SHIFT     6
`define RDAS_PI_ISHIFT     14
`define RDAS_PI_PSHIFT     12
`define RDAS_COEF_PASS     10'h3ff
`define RDAS_SETUP_SYNC2   3'b010
`define RDAS_SETUP_SYNC3   3'b011

`endif

// file: core/rdas_pkg.sv
// Types shared by the receive baseband modules.
package rdas_pkg;

  // Demodulator data path select.
  typedef enum logic [1:0] {
    DM_LIN  = 2'b00,
    DM_CORR = 2'b01,
    DM_ASK  = 2'b10,
    DM_RSV  = 2'b11
  } rdas_dsel_t;

  // Whole state of the top module.
  typedef struct packed {
    rdas_dsel_t        dsel;
    logic [2:0]        setup;
    logic              afc_en;
    logic              dot;
    logic              flip;
    logic [1:0]        slen;
    logic [1:0]        stol;
    logic [9:0]        post;
    logic [9:0]        disc;
    logic [7:0]        ddiv;
    logic [7:0]        cdiv;
    logic [7:0]        dcnt;
    logic [7:0]        ccnt;
    logic [15:0]       scale;
    logic [15:0]       ift;
    logic [23:0]       sword;
    logic              sample_en;
    logic              os_en;
    logic              bit_en;
    logic [4:0]        phase;
    logic              data_now;
    logic              data_prev;
    logic              rx_data;
    logic              rx_clk;
    logic signed [15:0] avg;
    logic signed [15:0] integ;
    logic signed [15:0] corr;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } rdas_top_st_t;

  // Whole state of the filter chain.
  typedef struct packed {
    logic [2:0][15:0] y;
  } rdas_filt_st_t;

  // Whole state of the sync detector except the checking count hc.
  typedef struct packed {
    logic [23:0] sh;
    logic [3:0]  hold;
    logic        match;
  } rdas_sync_st_t;

endpackage

// file: core/rdas_if.sv
// Carrier between the top module, the filter chain and the sync detector.
`timescale 1ns/1ps
`default_nettype none
interface rdas_if;
  logic              sample_en;  // Demodulator sample enable.
  logic              bit_en;     // Recovered bit strobe.
  logic              rx_bit;     // Recovered bit.
  logic signed [15:0] filt_x;    // Filter chain input.
  logic [9:0]        k0;         // First stage coefficient.
  logic [9:0]        k1;         // Post filter coefficient.
  logic signed [15:0] filt_y;    // Filter chain output.
  logic              sync_en;    // Detection allowed.
  logic [23:0]       sync_word;  // Word to look for.
  logic [1:0]        sync_len;   // Length code.
  logic [1:0]        sync_tol;   // Tolerated bit errors.
  logic              match;      // Match pin level.

  modport top  (output sample_en, bit_en, rx_bit, filt_x, k0, k1, sync_en, sync_word, sync_len, sync_tol,
                input filt_y, match);
  modport filt (input sample_en, filt_x, k0, k1, output filt_y);
  modport sync (input bit_en, rx_bit, sync_en, sync_word, sync_len, sync_tol, output match);
endinterface
`default_nettype wire

// file: core/rdas_lpf_chain.sv
// Cascade of first-order digital low-pass stages: correlator stage then second-order post filter.
`timescale 1ns/1ps
`default_nettype none
`include "rdas_consts.svh"
module rdas_lpf_chain (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Filter side of the carrier.
  rdas_if.filt      fi
);
  import rdas_pkg::*;

  rdas_filt_st_t st;   // Stage outputs.
  rdas_filt_st_t nxt;  // Next stage outputs.

  // ****************************************************************
  // Stage update: y += (in - y) * k / 1024, once per sample enable.
  // ****************************************************************
  always_comb begin
    logic [`RDAS_NSTAGE:0][15:0] taps;
    logic signed [16:0]          dif;
    logic signed [27:0]          prd;
    logic [10:0]                 cf;
    nxt  = st;
    taps = {st.y, fi.filt_x};
    dif  = '0;
    prd  = '0;
    cf   = '0;
    if (fi.sample_en) begin
      for (int i = 0; i < `RDAS_NSTAGE; i++) begin
        // Stage 0 follows the correlator code, the later two form the post filter.
        cf  = (i == 0) ? {1'b0, fi.k0} : {1'b0, fi.k1};
        dif = $signed({taps[i][15], taps[i]}) - $signed({st.y[i][15], st.y[i]});
        prd = dif * $signed(cf);
        // The step never overshoots the input, so the 16-bit wrap is exact.
        nxt.y[i] = st.y[i] + prd[`RDAS_COEF_SHIFT+15:`RDAS_COEF_SHIFT];
      end
    end
  end

  // State register.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign fi.filt_y = st.y[`RDAS_NSTAGE-1];
endmodule
`default_nettype wire

// file: core/rdas_sync_det.sv
// Sync/ID word detector with length, error tolerance and a nine-bit match pulse.
`timescale 1ns/1ps
`default_nettype none
`include "rdas_consts.svh"
module rdas_sync_det (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Detector side of the carrier.
  rdas_if.sync      si
);
  import rdas_pkg::*;

  rdas_sync_st_t st;     // Detector state.
  rdas_sync_st_t nxt;    // Next detector state.
  logic [4:0]    mism;   // Mismatches in the newest window.
  logic [3:0]    hc;     // Bit strobes seen while matched, for checking only.

  // ****************************************************************
  // Shift, compare and pulse control.
  // ****************************************************************
  always_comb begin
    logic [4:0]  len;
    logic [23:0] msk;
    logic [23:0] dif;
    nxt  = st;
    len  = `RDAS_SYNC_BASE + {1'b0, si.sync_len, 2'b00};
    msk  = ~(24'hffffff << len);
    dif  = '0;
    mism = '0;
    if (si.bit_en) begin
      // First bit in ends up highest, so the word is sent MSB first.
      nxt.sh = {st.sh[22:0], si.rx_bit};
      dif    = (nxt.sh ^ si.sync_word) & msk;
      for (int i = 0; i < `RDAS_SYNC_MAXLEN; i++) begin
        mism = mism + {4'h0, dif[i]};
      end
      if (st.match) begin
        // Release after the ninth recovered clock.
        nxt.hold = st.hold - 4'd1;
        if (st.hold == 4'd1) begin
          nxt.match = 1'b0;
        end
      end else if (si.sync_en && (mism <= {3'b000, si.sync_tol})) begin
        nxt.match = 1'b1;
        nxt.hold  = `RDAS_HOLD_BITS;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  // Helper count for the pulse-length check.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hc <= '0;
    end else if (!st.match) begin
      hc <= '0;
    end else if (si.bit_en) begin
      hc <= hc + 4'd1;
    end
  end

  assign si.match = st.match;

  match_hold_a:
    assert property (@(posedge mclk) disable iff (sys_rst) $fell(st.match) |-> hc == `RDAS_HOLD_BITS)
      else $error("Match pulse did not last nine bit clocks.");

  match_tol_a:
    assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(st.match) |-> $past(si.bit_en) && ($past(mism) <= {3'b000, $past(si.sync_tol)}))
      else $error("Match raised with too many bit errors.");

  match_en_a:
    assert property (@(posedge mclk) disable iff (sys_rst) $rose(st.match) |-> $past(si.sync_en))
      else $error("Match raised while detection disabled.");
endmodule
`default_nettype wire

// file: core/rdas_top.sv
// Receive baseband: demodulator select, filtering, slicing, clock recovery, AFC and sync detection.
//
// Function
// - Clock recovery oversamples at 32x data rate.
// - Recovery stays locked within two percent error.
// - Two-bit select: correlator, linear, ASK.
// - Ten-bit code sets correlator bandwidth.
// - Two coefficient bits follow parity of K.
// - Ten-bit code sets post filter cutoff.
// - Linear mode: average, envelope, slice, recover.
// - ASK mode filters and envelopes signal strength.
// - AFC only in FSK, uses envelope estimate.
// - Signed 16-bit frequency estimate readable.
// - Enable bit starts proportional-integral correction.
// - AFC corrects up to fifty kilohertz.
// - AFC settles within about 48 bits.
// - Compare sync word, raise match pin.
// - Match pin drops after nine data clocks.
// - Sync detection only in setup 010/011.
// - Sync length 12, 16, 20 or 24.
// - Up to three mismatched bits tolerated.
// - Correlator slicer threshold fixed at zero.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "rdas_consts.svh"
module rdas_top #(
  parameter logic signed [15:0] AFC_LIMIT = `RDAS_RST_AFCLIM  // Correction bound, synthesizer units.
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Digitised receiver inputs, valid at every demodulator sample.
  input  wire logic [15:0] corr_diff_in,
  input  wire logic [15:0] disc_freq_in,
  input  wire logic [6:0]  rssi_in,
  // Recovered data, clock, match pin and synthesizer correction.
  output logic             rx_data,
  output logic             rx_clk,
  output logic             sync_match,
  output logic [15:0]      afc_corr
);
  import rdas_pkg::*;

  rdas_top_st_t st;    // All state of the block.
  rdas_top_st_t nxt;   // Next state.
  rdas_if       ifc(); // Carrier to the two submodules.

  logic signed [15:0] raw_fsk;   // Discriminator sample.
  logic signed [15:0] raw_ask;   // Signal strength as a signed sample.
  logic               fsk_mode;  // One of the two FSK paths is active.

  // ****************************************************************
  // Input selection
  // ****************************************************************

  assign raw_fsk  = $signed(disc_freq_in);
  assign raw_ask  = $signed({9'h000, rssi_in});
  assign fsk_mode = (st.dsel == DM_LIN) || (st.dsel == DM_CORR);

  // The filter input follows the demodulator select. The dot product bit
  // chooses the sign convention of the correlator difference.
  always_comb begin
    case (st.dsel)
      DM_CORR: begin
        ifc.filt_x = st.dot ? -$signed(corr_diff_in) : $signed(corr_diff_in);
      end
      DM_LIN: begin
        ifc.filt_x = raw_fsk;
      end
      DM_ASK: begin
        ifc.filt_x = raw_ask;
      end
      default: begin
        ifc.filt_x = '0;
      end
    endcase
  end

  // Correlator stage only narrows in correlator mode; elsewhere it passes.
  assign ifc.k0        = (st.dsel == DM_CORR) ? st.disc : `RDAS_COEF_PASS;
  assign ifc.k1        = st.post;
  assign ifc.sample_en = st.sample_en;
  assign ifc.bit_en    = st.bit_en;
  assign ifc.rx_bit    = st.rx_data;
  assign ifc.sync_en   = (st.setup == `RDAS_SETUP_SYNC2) || (st.setup == `RDAS_SETUP_SYNC3);
  assign ifc.sync_word = st.sword;
  assign ifc.sync_len  = st.slen;
  assign ifc.sync_tol  = st.stol;

  // ****************************************************************
  // Submodules
  // ****************************************************************

  // Correlator stage plus second-order post filter.
  rdas_lpf_chain u_lpf (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .fi      (ifc)
  );

  // Sync word detector driving the match pin.
  rdas_sync_det u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .si      (ifc)
  );

  // Saturates a wide signed value to the correction bound.
  function automatic logic signed [15:0] clamp_corr(input logic signed [33:0] v);
    logic signed [33:0] lim;
    lim = {{18{AFC_LIMIT[15]}}, AFC_LIMIT};
    if (v > lim) begin
      return AFC_LIMIT;
    end else if (v < -lim) begin
      return -AFC_LIMIT;
    end
    return v[15:0];
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic signed [15:0] avg_in;
    logic signed [16:0] adif;
    logic signed [16:0] err;
    logic signed [33:0] prd;
    logic signed [33:0] isum;
    logic signed [33:0] tot;
    logic               slice;
    logic               hit;
    logic [31:0]        rd;
    nxt    = st;
    avg_in = '0;
    adif   = '0;
    err    = '0;
    prd    = '0;
    isum   = '0;
    tot    = '0;
    slice  = st.data_now;
    hit    = 1'b1;
    rd     = '0;

    // Demodulator sample enable from the system clock divider.
    nxt.sample_en = 1'b0;
    if (st.dcnt == st.ddiv) begin
      nxt.dcnt      = '0;
      nxt.sample_en = 1'b1;
    end else begin
      nxt.dcnt = st.dcnt + 8'd1;
    end

    // Oversampling enable; software sets it to 32 times the data rate.
    nxt.os_en = 1'b0;
    if (st.ccnt == st.cdiv) begin
      nxt.ccnt  = '0;
      nxt.os_en = 1'b1;
    end else begin
      nxt.ccnt = st.ccnt + 8'd1;
    end

    // Averaging envelope: discriminator in FSK, signal strength in ASK.
    if (st.sample_en) begin
      avg_in  = (st.dsel == DM_ASK) ? raw_ask : raw_fsk;
      adif    = $signed({avg_in[15], avg_in}) - $signed({st.avg[15], st.avg});
      nxt.avg = st.avg + 16'(adif >>> `RDAS_AVG_SHIFT);
      // Slicer: zero in correlator mode, the envelope average in linear and ASK modes.
      case (st.dsel)
        DM_CORR: begin
          slice = ifc.filt_y > 16'sd0;
        end
        DM_LIN: begin
          slice = ifc.filt_y > st.avg;
        end
        DM_ASK: begin
          slice = ifc.filt_y > st.avg;
        end
        default: begin
          slice = st.data_now;
        end
      endcase
      nxt.data_now = (st.dsel == DM_RSV) ? st.data_now : (slice ^ st.flip);
    end

    // Clock recovery: a 32-step phase counter nudged by data edges.
    nxt.bit_en = 1'b0;
    if (st.os_en) begin
      nxt.data_prev = st.data_now;
      nxt.bit_en    = (st.phase == `RDAS_OS_MID);
      if (st.phase == `RDAS_OS_MID) begin
        nxt.rx_data = st.data_now;
      end
      // An edge seen late, in the first half, holds the phase; one seen early, in the second half, skips a step.
      // One step per edge covers about three percent of rate error.
      if ((st.data_now != st.data_prev) && (st.phase != 5'd0)) begin
        nxt.phase = (st.phase < `RDAS_OS_HALF) ? st.phase : st.phase + `RDAS_OS_LEAD;
      end else begin
        nxt.phase = st.phase + `RDAS_OS_STEP;
      end
      nxt.rx_clk = nxt.phase[4];
    end

    // Frequency control, updated once per recovered bit so that the
    // settling time scales with the data rate.
    if (!(st.afc_en && fsk_mode)) begin
      nxt.integ = '0;
      nxt.corr  = '0;
    end else if (st.bit_en) begin
      err       = $signed({st.avg[15], st.avg}) - $signed({1'b0, st.ift});
      prd       = err * $signed({1'b0, st.scale});
      isum      = {{18{st.integ[15]}}, st.integ} + (prd >>> `RDAS_PI_ISHIFT);
      nxt.integ = clamp_corr(isum);
      tot       = {{18{nxt.integ[15]}}, nxt.integ} + (prd >>> `RDAS_PI_PSHIFT);
      nxt.corr  = clamp_corr(tot);
    end

    // APB read mux.
    case (paddr)
      `RDAS_OFF_CTRL: begin
        rd[`RDAS_CTRL_DSEL]  = st.dsel;
        rd[`RDAS_CTRL_SETUP] = st.setup;
        rd[`RDAS_CTRL_AFCEN] = st.afc_en;
        rd[`RDAS_CTRL_DOT]   = st.dot;
        rd[`RDAS_CTRL_FLIP]  = st.flip;
        rd[`RDAS_CTRL_SLEN]  = st.slen;
        rd[`RDAS_CTRL_STOL]  = st.stol;
      end
      `RDAS_OFF_BW: begin
        rd[`RDAS_BW_POST] = st.post;
        rd[`RDAS_BW_DISC] = st.disc;
      end
      `RDAS_OFF_CLKDIV: begin
        rd[`RDAS_DIV_DEMOD] = st.ddiv;
        rd[`RDAS_DIV_CDR]   = st.cdiv;
      end
      `RDAS_OFF_AFC: begin
        rd[`RDAS_AFC_SCALE] = st.scale;
        rd[`RDAS_AFC_IFT]   = st.ift;
      end
      `RDAS_OFF_SYNC: begin
        rd[`RDAS_SYNC_WORD] = st.sword;
      end
      `RDAS_OFF_FEST: begin
        rd = {st.corr, st.avg};
      end
      `RDAS_OFF_STAT: begin
        rd[2:0] = {ifc.match, st.rx_clk, st.rx_data};
      end
      default: begin
        hit = 1'b0;
      end
    endcase

    // APB: answer one cycle into the access phase, commit at the pready edge.
    nxt.pready  = 1'b0;
    nxt.pslverr = 1'b0;
    nxt.prdata  = '0;
    if (psel && penable && !st.pready) begin
      nxt.pready  = 1'b1;
      nxt.pslverr = !hit;
      nxt.prdata  = pwrite ? 32'h0000_0000 : rd;
    end
    if (psel && penable && st.pready && pwrite) begin
      case (paddr)
        `RDAS_OFF_CTRL: begin
          nxt.dsel   = rdas_dsel_t'(pwdata[`RDAS_CTRL_DSEL]);
          nxt.setup  = pwdata[`RDAS_CTRL_SETUP];
          nxt.afc_en = pwdata[`RDAS_CTRL_AFCEN];
          nxt.dot    = pwdata[`RDAS_CTRL_DOT];
          nxt.flip   = pwdata[`RDAS_CTRL_FLIP];
          nxt.slen   = pwdata[`RDAS_CTRL_SLEN];
          nxt.stol   = pwdata[`RDAS_CTRL_STOL];
        end
        `RDAS_OFF_BW: begin
          nxt.post = pwdata[`RDAS_BW_POST];
          nxt.disc = pwdata[`RDAS_BW_DISC];
        end
        `RDAS_OFF_CLKDIV: begin
          nxt.ddiv = pwdata[`RDAS_DIV_DEMOD];
          nxt.cdiv = pwdata[`RDAS_DIV_CDR];
        end
        `RDAS_OFF_AFC: begin
          nxt.scale = pwdata[`RDAS_AFC_SCALE];
          nxt.ift   = pwdata[`RDAS_AFC_IFT];
        end
        `RDAS_OFF_SYNC: begin
          nxt.sword = pwdata[`RDAS_SYNC_WORD];
        end
        default: begin
          nxt.sword = st.sword;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st       <= '0;
      st.dsel  <= DM_CORR;
      st.post  <= `RDAS_RST_POST;
      st.disc  <= `RDAS_RST_DISC;
      st.ddiv  <= `RDAS_RST_DDIV;
      st.cdiv  <= `RDAS_RST_CDIV;
      st.scale <= `RDAS_RST_SCALE;
      st.ift   <= `RDAS_RST_IFT;
    end else begin
      st <= nxt;
    end
  end

  // Outputs straight from state flip-flops.
  assign prdata     = st.prdata;
  assign pready     = st.pready;
  assign pslverr    = st.pslverr;
  assign rx_data    = st.rx_data;
  assign rx_clk     = st.rx_clk;
  assign sync_match = ifc.match;
  assign afc_corr   = st.corr;

  // ****************************************************************
  // Checks
  // ****************************************************************

  bit_mid_a:
    assert property (@(posedge mclk) disable iff (sys_rst)
      st.bit_en |-> $past(st.os_en) && ($past(st.phase) == `RDAS_OS_MID))
      else $error("Bit strobe away from mid-bit phase.");

  phase_step_a:
    assert property (@(posedge mclk) disable iff (sys_rst)
      st.os_en |=> (5'(st.phase - $past(st.phase)) <= `RDAS_OS_LEAD))
      else $error("Phase moved by more than two steps.");

  corr_slice_a:
    assert property (@(posedge mclk) disable iff (sys_rst)
      st.sample_en && (st.dsel == DM_CORR) && !st.flip |=> st.data_now == ($past(ifc.filt_y) > 16'sd0))
      else $error("Correlator slicer not at zero threshold.");

  afc_off_a:
    assert property (@(posedge mclk) disable iff (sys_rst)
      !(st.afc_en && fsk_mode) |=> st.corr == 16'sd0)
      else $error("Correction active outside enabled FSK mode.");

  afc_range_a:
    assert property (@(posedge mclk) disable iff (sys_rst)
      (st.corr <= AFC_LIMIT) && (st.corr >= -AFC_LIMIT))
      else $error("Correction beyond its bound.");
endmodule
`default_nettype wire

// file: verif/rdas_tx_model.sv
// Remote transmitter model: endless frames of preamble then sync word.
`timescale 1ns/1ps
`default_nettype none
module rdas_tx_model #(
  parameter int BIT_CYC = 32  // Bit period in mclk cycles.
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Word to send.
  input  wire logic [23:0] word,
  // Digitised receiver samples.
  output logic [15:0]      corr_diff_in,
  output logic [15:0]      disc_freq_in,
  output logic [6:0]       rssi_in
);
  int   cyc_ff;  // Cycle within the bit.
  int   idx_ff;  // Bit within the frame.
  logic bit_v;   // Bit on air.
  // ************************************
  // Frame sequencer
  // ************************************
  // A 16-bit alternating preamble lets the recovery loop lock before the word.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cyc_ff <= 0;
      idx_ff <= 0;
    end else if (cyc_ff == BIT_CYC - 1) begin
      cyc_ff <= 0;
      idx_ff <= (idx_ff == 39) ? 0 : idx_ff + 1;
    end else begin
      cyc_ff <= cyc_ff + 1;
    end
  end
  // Word goes out most significant bit first.
  assign bit_v = (idx_ff < 16) ? ~idx_ff[0] : word[39 - idx_ff];
  // Antipodal correlator levels so that a zero threshold separates them.
  assign corr_diff_in = bit_v ? 16'h4000 : 16'hc000;
  assign disc_freq_in = bit_v ? 16'h1400 : 16'h0c00;
  assign rssi_in      = bit_v ? 7'h60 : 7'h10;
endmodule
`default_nettype wire

// file: verif/test_rdas_top.sv
// Self-checking bench for the receive baseband block.
`timescale 1ns/1ps
`default_nettype none
module test_rdas_top;
  logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, rx_data, rx_clk, sync_match, e, seen, clr, pr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] corr, disc, afc;
  logic [6:0]  rssi;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          n;
  int          m;
  rdas_top dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .corr_diff_in(corr), .disc_freq_in(disc), .rssi_in(rssi), .rx_data(rx_data), .rx_clk(rx_clk),
    .sync_match(sync_match), .afc_corr(afc));
  rdas_tx_model far (.mclk(mclk), .sys_rst(sys_rst), .word(24'hb4d2c3), .corr_diff_in(corr),
    .disc_freq_in(disc), .rssi_in(rssi));
  // Sticky flag: any match pulse while the clear request is low.
  always @(posedge mclk) seen <= clr ? 1'b0 : (seen | (sync_match === 1'b1));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // One APB transfer; called just after a rising edge. Only the watchdog ends a wait that never gets pready.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Range compare for values that ripple with the received data.
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_compared++;
    if ($isunknown(got) || (got < lo) || (got > hi)) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic report_and_stop();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog sized well above the longest scenario.
  initial begin
    #(25.0 * 40000);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; clr = 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    // Reset values, then an unmapped read and an ignored read-only write.
    apb(1'b0, 8'h04, 32'h0); chk(q, 32'h003f0009);
    apb(1'b0, 8'h00, 32'h0); chk(q, 32'h00000001);
    apb(1'b0, 8'h1c, 32'h0); chk({q[30:0], e}, 32'h00000001);
    apb(1'b1, 8'h14, 32'hffffffff); apb(1'b0, 8'h08, 32'h0); chk(q, 32'h00008107);
    // Fast clocks: one oversample per mclk, so 32 mclk per bit as the model sends.
    apb(1'b1, 8'h08, 32'h0);
    // Post filter at 0.75 of the 1.25 Mbit/s rate: 2^10 * 2 pi * 937.5 kHz / 40 MHz rounds to 151.
    apb(1'b1, 8'h04, 32'h03ff0097);
    // The loop_scale_coeff for a crystal_freq of 10 MHz: 500 * 2^24 / 1e7 rounds to 839.
    apb(1'b1, 8'h0c, 32'h051f0347);
    apb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h051f0347);
    apb(1'b1, 8'h10, 32'h00b4d2c3);
    // ASK with the loop enabled must not correct; the peak response factor of six sits outside this block.
    apb(1'b1, 8'h00, 32'h00000022);
    repeat (500) @(posedge mclk);
    chk({16'h0, afc}, 32'h0);
    // Linear FSK with the loop on: the estimate lies between the tone levels, above the target, so it corrects upward.
    apb(1'b1, 8'h00, 32'h00000020);
    repeat (2000) @(posedge mclk);
    chk_rng({16'h0, afc}, 32'h00000001, 32'h00004000);
    apb(1'b0, 8'h14, 32'h0);
    chk_rng({16'h0, q[15:0]}, 32'h00000c00, 32'h00001400);
    // Correlator, 24-bit word, setup 000: no detection. Sign bits stay clear, as the model's levels need.
    apb(1'b1, 8'h00, 32'h00000301);
    clr <= 1'b0;
    repeat (3000) @(posedge mclk); chk({31'h0, seen}, 32'h0);
    // Setup 010: match appears within a frame and lasts nine recovered clocks.
    apb(1'b1, 8'h00, 32'h00000309);
    n = 0;
    while (sync_match !== 1'b1 && n < 4000) begin @(posedge mclk); n++; end
    chk({31'h0, sync_match}, 32'h1);
    // The bit that completed the word is the word's last bit, a one.
    chk({31'h0, rx_data}, 32'h1);
    // Count recovered clock rises, sampled on mclk, while the pin stays high.
    n = 0;
    m = 0;
    pr = rx_clk;
    while (sync_match === 1'b1 && m < 1000) begin
      @(posedge mclk);
      m++;
      if (rx_clk === 1'b1 && pr === 1'b0) n++;
      pr = rx_clk;
    end
    chk(n, 32'd9);
    report_and_stop();
  end
endmodule
`default_nettype wire
